//--- tps_defs.svh
// Register indices, field positions, reset values and timing counts of the timer prescaler
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH

// Register indices; the byte address is four times the index
`define TPS_IDX_TIMER 8'h01
`define TPS_IDX_INTCTL 8'h0B
`define TPS_IDX_OPTION 8'h81

// Option register fields
`define TPS_OPT_RATE_LSB 0
`define TPS_OPT_RATE_MSB 2
`define TPS_OPT_OWNER 3
`define TPS_OPT_EDGE 4
`define TPS_OPT_SRC 5

// Interrupt control fields
`define TPS_INT_FLAG 2
`define TPS_INT_EN 5

// Reset values
`define TPS_RST_OPTION 8'hFF
`define TPS_RST_INTCTL 8'h00
`define TPS_RST_TIMER 8'h00

// Timing
`define TPS_MCLK_NS 50
`define TPS_INSTR_NS 200
`define TPS_INSTR_CYC (`TPS_INSTR_NS / `TPS_MCLK_NS)
`define TPS_WR_INHIBIT 2'h2

`endif

//--- tps_pkg.sv
// Types shared by the timer prescaler modules
package tps_pkg;
    typedef enum logic {
        TPS_OWN_TIMER,
        TPS_OWN_WDT
    } tps_owner_t;
    typedef logic [2:0] tps_rate_t;
endpackage : tps_pkg

//--- tps_tick_if.sv
// Signals between the timer core and the shared prescaler
`timescale 1ns/1ns
interface tps_tick_if;
    logic event_;
    logic clear;
    tps_pkg::tps_owner_t owner;
    tps_pkg::tps_rate_t rate;
    logic out;
    modport core (output event_, clear, owner, rate, input out);
    modport pre (input event_, clear, owner, rate, output out);
endinterface : tps_tick_if

//--- tps_prescaler.sv
// Shared prescaler: counts events and emits one pulse per selected ratio
`timescale 1ns/1ns
module tps_prescaler #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Core side
    tps_tick_if.pre tick
);
    logic [WIDTH-1:0] count;
    logic [3:0] shift;
    logic [WIDTH-1:0] mask;

    function automatic logic [WIDTH-1:0] lowMask(input logic [3:0] n);
        lowMask = (WIDTH'(1) << n) - WIDTH'(1);
    endfunction : lowMask

    // Timer divides by 2^(rate+1), watchdog by 2^rate
    always_comb begin
        shift = {1'b0, tick.rate};
        if (tick.owner == tps_pkg::TPS_OWN_TIMER) begin
            shift = shift + 4'h1;
        end
    end
    assign mask = lowMask(shift);
    assign tick.out = tick.event_ && ((count & mask) == mask);

    // Count is internal only; no path reads or loads it from outside
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (tick.clear) begin
            count <= '0;
        end else if (tick.event_) begin
            count <= count + WIDTH'(1);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    clear_zeroes_a: assert property (tick.clear |=> count == '0)
        else $error("prescaler not cleared");
    timer_ratio_a: assert property (
        tick.out && tick.owner == tps_pkg::TPS_OWN_TIMER |-> count[0])
        else $error("timer ratio below 1:2");
    wdt_bypass_a: assert property (
        tick.event_ && tick.owner == tps_pkg::TPS_OWN_WDT && tick.rate == 3'h0 |-> tick.out)
        else $error("watchdog 1:1 ratio missed");
endmodule : tps_prescaler

//--- tps_edge_sync.sv
// Synchronises the external count pin and picks the counting edge
`timescale 1ns/1ns
module tps_edge_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pin and edge choice
    input wire logic countPin,
    input wire logic fallingSel,
    // Edge pulse
    output logic edgeEvent
);
    logic sync1;
    logic sync2;
    logic prev;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
        end else begin
            sync1 <= countPin;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    assign edgeEvent = fallingSel ? (prev && !sync2) : (sync2 && !prev);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    edge_polarity_a: assert property (
        edgeEvent |-> (fallingSel ? $fell(sync2) : $rose(sync2)))
        else $error("count edge of wrong polarity");
endmodule : tps_edge_sync

//--- tps_timer.sv
// Timer core with shared watchdog/timer prescaler and APB registers
// Contract
// - Prescaler serves timer or watchdog only; the other runs unscaled.
// - Prescaler count cannot be read or loaded by software.
// - Owner bit and three-bit rate live in option bits 3:0.
// - Any timer register write clears prescaler while timer owns it.
// - Watchdog clear instruction clears prescaler while watchdog owns it.
// - Timer write leaves the owner bit unchanged.
// - Timer ratio is 2 times two to the rate: 1:2 to 1:256.
// - Watchdog ratio is two to the rate: 1:1 to 1:128.
// - Source bit clear counts instruction cycles, set counts pin edges.
// - Edge bit clear counts rising pin edges, set counts falling.
// - Wrap FFh to 00h sets sticky flag; enable bit masks interrupt.
// - Timer write suppresses increments for the next two instruction cycles.
`timescale 1ns/1ns
`include "tps_defs.svh"
module tps_timer #(
    parameter int INSTR_CYC = `TPS_INSTR_CYC,
    parameter int PRE_WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External count pin
    input wire logic countPin,
    // Watchdog side
    input wire logic wdtClear,
    input wire logic wdtTimeout,
    output logic wdtTimeoutScaled,
    // Interrupt
    output logic irq
);
    logic [7:0] optionCfg;
    logic [7:0] intCtl;
    logic [7:0] timerCount;
    logic [7:0] instrCnt;
    logic instrTick;
    logic pinEdge;
    logic srcEvent;
    logic timerStep;
    logic timerInc;
    logic [1:0] inhibit;
    logic setup;
    logic access;
    logic apbWr;
    logic hitTimer;
    logic hitIntCtl;
    logic hitOption;
    logic wrTimer;
    logic wrIntCtl;
    logic wrOption;
    logic overflow;
    logic next_flag;
    tps_pkg::tps_owner_t owner;

    tps_tick_if tick ();

    function automatic logic [11:0] regAddr(input logic [7:0] idx);
        regAddr = {2'b00, idx, 2'b00};
    endfunction : regAddr

    // Instruction cycle enable from the master clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            instrCnt <= 8'h00;
        end else if (instrCnt == 8'(INSTR_CYC - 1)) begin
            instrCnt <= 8'h00;
        end else begin
            instrCnt <= instrCnt + 8'h01;
        end
    end
    assign instrTick = (instrCnt == 8'(INSTR_CYC - 1));

    tps_edge_sync u_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .countPin(countPin),
        .fallingSel(optionCfg[`TPS_OPT_EDGE]),
        .edgeEvent(pinEdge)
    );

    // Count source and prescaler routing
    assign srcEvent = optionCfg[`TPS_OPT_SRC] ? pinEdge : instrTick;
    assign owner = tps_pkg::tps_owner_t'(optionCfg[`TPS_OPT_OWNER]);

    assign tick.owner = owner;
    assign tick.rate = optionCfg[`TPS_OPT_RATE_MSB:`TPS_OPT_RATE_LSB];
    assign tick.event_ = (owner == tps_pkg::TPS_OWN_TIMER) ? srcEvent : wdtTimeout;
    assign tick.clear = (owner == tps_pkg::TPS_OWN_TIMER) ? wrTimer : wdtClear;

    tps_prescaler #(
        .WIDTH(PRE_WIDTH)
    ) u_pre (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(tick)
    );

    // Unscaled path for whichever party does not own the prescaler
    assign timerStep = (owner == tps_pkg::TPS_OWN_TIMER) ? tick.out : srcEvent;
    assign wdtTimeoutScaled = (owner == tps_pkg::TPS_OWN_WDT) ? tick.out : wdtTimeout;
    assign timerInc = timerStep && (inhibit == 2'h0);
    assign overflow = timerInc && (timerCount == 8'hFF);

    // APB decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign apbWr = access && pwrite;
    assign hitTimer = (paddr == regAddr(`TPS_IDX_TIMER));
    assign hitIntCtl = (paddr == regAddr(`TPS_IDX_INTCTL));
    assign hitOption = (paddr == regAddr(`TPS_IDX_OPTION));
    assign wrTimer = apbWr && hitTimer;
    assign wrIntCtl = apbWr && hitIntCtl;
    assign wrOption = apbWr && hitOption;
    assign pready = access;
    assign pslverr = access && !(hitTimer || hitIntCtl || hitOption);

    // Read data is captured in the setup phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            if (hitTimer) begin
                prdata <= {24'h00_0000, timerCount};
            end else if (hitIntCtl) begin
                prdata <= {24'h00_0000, intCtl};
            end else if (hitOption) begin
                prdata <= {24'h00_0000, optionCfg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Option register; a timer write never touches it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            optionCfg <= `TPS_RST_OPTION;
        end else if (wrOption) begin
            optionCfg <= pwdata[7:0];
        end
    end

    // Timer count: a write wins over an increment
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timerCount <= `TPS_RST_TIMER;
        end else if (wrTimer) begin
            timerCount <= pwdata[7:0];
        end else if (timerInc) begin
            timerCount <= timerCount + 8'h01;
        end
    end

    // Increment suppression after a timer write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inhibit <= 2'h0;
        end else if (wrTimer) begin
            inhibit <= `TPS_WR_INHIBIT;
        end else if (instrTick && inhibit != 2'h0) begin
            inhibit <= inhibit - 2'h1;
        end
    end

    // Overflow flag: set wins over a write-one clear
    always_comb begin
        next_flag = intCtl[`TPS_INT_FLAG];
        if (wrIntCtl && pwdata[`TPS_INT_FLAG]) begin
            next_flag = 1'b0;
        end
        if (overflow) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            intCtl <= `TPS_RST_INTCTL;
        end else begin
            if (wrIntCtl) begin
                intCtl[7:3] <= pwdata[7:3];
                intCtl[1:0] <= pwdata[1:0];
            end
            intCtl[`TPS_INT_FLAG] <= next_flag;
        end
    end

    assign irq = intCtl[`TPS_INT_FLAG] && intCtl[`TPS_INT_EN];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence wrapSeen;
        timerInc && timerCount == 8'hFF && !wrTimer;
    endsequence

    overflow_flag_a: assert property (
        wrapSeen |=> intCtl[`TPS_INT_FLAG] && timerCount == 8'h00)
        else $error("wrap did not set flag");
    irq_mask_a: assert property (
        $rose(irq) |-> intCtl[`TPS_INT_EN] && intCtl[`TPS_INT_FLAG])
        else $error("interrupt raised while masked");
    write_inhibit_a: assert property (
        wrTimer |=> inhibit == 2'h2 && timerCount == $past(pwdata[7:0]))
        else $error("timer write not loaded or not inhibited");
    no_step_a: assert property (
        timerInc |-> inhibit == 2'h0)
        else $error("timer stepped while inhibited");
    owner_kept_a: assert property (
        wrTimer && !wrOption |=> $stable(optionCfg[`TPS_OPT_OWNER]))
        else $error("timer write changed owner");
    internal_src_a: assert property (
        timerStep && owner == tps_pkg::TPS_OWN_WDT && !optionCfg[`TPS_OPT_SRC] |-> instrTick)
        else $error("internal source stepped off instruction cycle");
    unscaled_step_a: assert property (
        timerInc && owner == tps_pkg::TPS_OWN_WDT && !wrTimer
        |=> timerCount == $past(timerCount) + 8'h01)
        else $error("timer did not step once");
    wdt_direct_a: assert property (
        owner == tps_pkg::TPS_OWN_TIMER |-> wdtTimeoutScaled == wdtTimeout)
        else $error("watchdog scaled while timer owns prescaler");
    read_option_a: assert property (
        setup && !pwrite && hitOption |=> prdata[7:0] == $past(optionCfg))
        else $error("option read data wrong");

    // Prescaler clear follows its owner
    prescale_clear_a: assert property (
        owner == tps_pkg::TPS_OWN_TIMER && wrTimer |-> tick.clear)
        else $error("timer write left prescaler running");
    wdt_clear_a: assert property (
        owner == tps_pkg::TPS_OWN_WDT && wdtClear |-> tick.clear)
        else $error("watchdog clear left prescaler running");

    // Option fields taken from a write and count source selection
    owner_load_a: assert property (
        wrOption |=> owner == tps_pkg::tps_owner_t'($past(pwdata[`TPS_OPT_OWNER])))
        else $error("owner bit not taken from option write");
    rate_load_a: assert property (
        wrOption |=> tick.rate == $past(pwdata[`TPS_OPT_RATE_MSB:`TPS_OPT_RATE_LSB]))
        else $error("rate field not taken from option write");
    source_pin_a: assert property (
        optionCfg[`TPS_OPT_SRC] && !pinEdge |-> !timerStep)
        else $error("pin mode stepped without a pin edge");
    source_instr_a: assert property (
        !optionCfg[`TPS_OPT_SRC] && !instrTick |-> !timerStep)
        else $error("timer mode stepped off instruction cycle");

    // Two-cycle suppression after a timer write
    sequence inhibitFirstTick;
        instrTick && inhibit == 2'h2 && !wrTimer;
    endsequence

    sequence inhibitLastTick;
        instrTick && inhibit == 2'h1 && !wrTimer;
    endsequence

    inhibit_step_a: assert property (
        inhibitFirstTick |=> inhibit == 2'h1)
        else $error("inhibit did not count first cycle");
    inhibit_end_a: assert property (
        inhibitLastTick |=> inhibit == 2'h0)
        else $error("inhibit did not end after two cycles");
    inhibit_hold_a: assert property (
        !instrTick && !wrTimer |=> $stable(inhibit))
        else $error("inhibit changed off instruction cycle");

    // Overflow flag and its mask
    flag_wins_a: assert property (
        overflow && wrIntCtl |=> intCtl[`TPS_INT_FLAG])
        else $error("clear beat overflow set");
    flag_sticky_a: assert property (
        intCtl[`TPS_INT_FLAG] && !wrIntCtl |=> intCtl[`TPS_INT_FLAG])
        else $error("overflow flag dropped by itself");
    flag_clear_a: assert property (
        wrIntCtl && pwdata[`TPS_INT_FLAG] && !overflow |=> !intCtl[`TPS_INT_FLAG])
        else $error("write one did not clear flag");
    flag_cause_a: assert property (
        !intCtl[`TPS_INT_FLAG] && !overflow |=> !intCtl[`TPS_INT_FLAG])
        else $error("flag set without overflow");
    irq_masked_a: assert property (
        !intCtl[`TPS_INT_EN] |-> !irq)
        else $error("interrupt not masked");

    // Timer count moves only by a step or a write
    scaled_step_a: assert property (
        timerInc && owner == tps_pkg::TPS_OWN_TIMER && !wrTimer
        |=> timerCount == $past(timerCount) + 8'h01)
        else $error("timer did not step on prescaler pulse");
    timer_hold_a: assert property (
        !timerInc && !wrTimer |=> $stable(timerCount))
        else $error("timer moved without a step");

    // Register bus
    unmapped_write_a: assert property (
        apbWr && pslverr |=> $stable(optionCfg) && $stable(intCtl[7:3]))
        else $error("unmapped write changed a register");
    read_upper_a: assert property (
        prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
endmodule : tps_timer

//--- tps_timer_test.sv
// Self-checking testbench for the timer core with its shared prescaler
`timescale 1ns/1ns
`include "tps_defs.svh"
module tps_timer_test;
    localparam logic [11:0] ATMR = {2'h0, `TPS_IDX_TIMER, 2'h0};
    localparam logic [11:0] AINT = {2'h0, `TPS_IDX_INTCTL, 2'h0};
    localparam logic [11:0] AOPT = {2'h0, `TPS_IDX_OPTION, 2'h0};
    logic mclk, rst_n, psel, penable, pwrite, countPin, wdtClear, wdtTimeout;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic pready, pslverr, wdtTimeoutScaled, irq, err;
    logic [7:0] a, b, d;
    int badCount, nCompared, scaled, n, mOpt;

    tps_timer u_tps_timer (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .countPin(countPin), .wdtClear(wdtClear),
        .wdtTimeout(wdtTimeout), .wdtTimeoutScaled(wdtTimeoutScaled), .irq(irq));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %0t mismatch got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic idle(input int k);
        repeat (k) @(posedge mclk);
    endtask : idle

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= addr;
        pwrite <= wr;
        pwdata <= data;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        if (wr && addr == AOPT) begin
            mOpt = int'(data[7:0]);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Timer increments seen over k instruction cycles, read at the same phase
    task automatic rate(input logic [7:0] opt, input int k, input int inc);
        apb(1'b1, AOPT, {24'h0, opt});
        apb(1'b1, ATMR, 32'h0);
        idle(20);
        apb(1'b0, ATMR, 32'h0);
        a = rd[7:0];
        idle(4 * k - 3);
        apb(1'b0, ATMR, 32'h0);
        check({24'h0, rd[7:0] - a}, 32'(inc));
    endtask : rate

    task automatic pulses(input logic clr, input int k);
        repeat (k) begin
            seed = lfsr(seed);
            @(posedge mclk);
            wdtTimeout <= ~clr;
            wdtClear <= clr;
            @(posedge mclk);
            wdtTimeout <= 1'b0;
            wdtClear <= 1'b0;
            idle(int'(seed[1:0]));
        end
    endtask : pulses

    task automatic pin(input logic [7:0] opt, input int rise);
        apb(1'b1, AOPT, {24'h0, opt});
        idle(10);
        apb(1'b0, ATMR, 32'h0);
        a = rd[7:0];
        seed = lfsr(seed);
        n = int'(seed[1:0]) + 1;
        repeat (n) begin
            countPin <= 1'b1;
            idle(4);
            countPin <= 1'b0;
            idle(4);
        end
        countPin <= 1'b1;
        idle(8);
        apb(1'b0, ATMR, 32'h0);
        b = rd[7:0];
        countPin <= 1'b0;
        idle(8);
        apb(1'b0, ATMR, 32'h0);
        check({24'h0, b - a}, 32'(n + rise));
        check({24'h0, rd[7:0] - b}, 32'(1 - rise));
    endtask : pin

    task automatic endOfTest;
        $display("Compared %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : endOfTest

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (wdtTimeoutScaled === 1'b1) begin
            scaled++;
        end
    end

    initial begin
        #2000000;
        badCount++;
        $display("ERROR %0t watchdog expired", $time);
        endOfTest();
    end

    initial begin
        seed = 32'hA6DC3C4C;
        {psel, penable, pwrite, countPin, wdtClear, wdtTimeout} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        badCount = 0;
        nCompared = 0;
        scaled = 0;
        mOpt = int'(`TPS_RST_OPTION);
        rst_n = 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, AOPT, 32'h0);
        check(rd, 32'(mOpt));
        apb(1'b0, AINT, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, ATMR, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        for (int r = 0; r < 8; r++) begin
            rate(8'(r), 5 << (r + 1), 5);
        end
        pulses(1'b1, 1);
        rate(8'h0F, 40, 40);
        for (int r = 0; r < 8; r++) begin
            apb(1'b1, AOPT, 32'h08 | 32'(r));
            pulses(1'b1, 1);
            scaled = 0;
            pulses(1'b0, 1 << r);
            idle(2);
            check(32'(scaled), 32'h1);
        end
        apb(1'b1, AOPT, 32'h0A);
        pulses(1'b1, 1);
        scaled = 0;
        pulses(1'b0, 3);
        pulses(1'b1, 1);
        pulses(1'b0, 3);
        idle(2);
        check(32'(scaled), 32'h0);
        pulses(1'b0, 1);
        idle(2);
        check(32'(scaled), 32'h1);
        apb(1'b1, AOPT, 32'h02);
        scaled = 0;
        pulses(1'b0, 3);
        idle(2);
        check(32'(scaled), 32'h3);
        apb(1'b1, AOPT, 32'h07);
        apb(1'b1, ATMR, 32'h0);
        idle(800);
        apb(1'b1, ATMR, 32'h10);
        idle(960);
        apb(1'b0, ATMR, 32'h0);
        check(rd, 32'h10);
        apb(1'b0, AOPT, 32'h0);
        check(rd, 32'(mOpt));
        pulses(1'b1, 1);
        apb(1'b1, AOPT, 32'h08);
        seed = lfsr(seed);
        apb(1'b1, ATMR, {24'h0, seed[7:0]});
        idle(39);
        apb(1'b0, ATMR, 32'h0);
        d = rd[7:0] - seed[7:0];
        check({24'h0, d}, 32'h8);
        pin(8'h28, 1);
        pin(8'h38, 0);
        apb(1'b1, AOPT, 32'h08);
        apb(1'b1, AINT, 32'h24);
        apb(1'b1, ATMR, 32'hFD);
        idle(40);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, AINT, 32'h0);
        check(rd, 32'h24);
        apb(1'b1, AINT, 32'h00);
        idle(2);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, AINT, 32'h0);
        check(rd, 32'h04);
        apb(1'b1, AINT, 32'h24);
        idle(2);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, AINT, 32'h0);
        check(rd, 32'h20);
        endOfTest();
    end
endmodule : tps_timer_test
